// ==== logic/ibis_core.sv ====
/*
  interface-function state of an instrument on a parallel instrument bus:
  address, bus/serial selection, remote/local, lockout, talker, listener,
  device clear and trigger pulses.
  assumes msg_valid/msg_code come from a decoder on sys_clk; ren and ifc
  are raw bus lines (active high asserted) and are synchronised here.
*/
`timescale 1ns/1ps
// Functional notes
// R1: address 0..30, factory bus on, address 16
// R2: controller keeps bus addresses unique
// R3: bus enable and serial enable exclusive
// R4: remote only on listen address with enable
// R5: measurement queries accepted only in remote
// R6: interface clear: local, talker/listener idle
// R7: interface clear keeps settings and data
// R8: controller holds interface clear 100 us
// R9: lockout disables panel except output off
// R10: lockout cleared by go-to-local or power
// R11: go-to-local returns remote to local
// R12: device clear acts without addressing
// R13: device clear flushes buffers and commands
// R14: device clear keeps settings and data
// R15: selective clear only when addressed listener
// R16: trigger only when bus is source
// R17: accepted trigger advances trigger model
// R18: remote locks panel keys except local
// R19: talker/listener exit on unt/unl/other/ifc
// R20: serial poll answered at any time
// R21: states shown as separate status outputs
module ibis_core #(
  parameter int IFC_CYC = ibis_pkg::IFC_MIN_CYC   // least interface clear hold, cycles
) (
  input  wire logic       sys_clk,                 // system clock 125 MHz
  input  wire logic       srst,                    // synchronous reset, power-on
  input  wire logic       clk_en,                  // clock enable
  input  wire logic       ren_pin,                 // remote enable line, asserted high
  input  wire logic       ifc_pin,                 // interface clear line, asserted high
  input  wire logic       msg_valid,               // decoded message strobe
  input  wire logic [3:0] msg_code,                // decoded message code
  input  wire logic       cfg_we,                  // write address/selection
  input  wire logic [4:0] cfg_addr,                // new primary address
  input  wire logic       cfg_bus_on,              // new bus selection
  input  wire logic       trig_src_bus,            // trigger source is the bus
  input  wire logic       query_req,               // measurement query request
  input  wire logic       local_key,               // local key press pulse
  input  wire logic [7:0] status_byte,             // status byte to poll out
  output logic [4:0]      prim_addr,               // primary address
  output logic            bus_enabled,             // parallel bus enabled
  output logic            serial_enabled,          // serial port enabled
  output logic            remote_state,            // in remote
  output logic            lockout_state,           // local lockout in effect
  output logic            talker_active,           // talker active
  output logic            listener_active_indicator, // listener active
  output logic            panel_keys_en,           // ordinary panel keys usable
  output logic            local_key_en,            // local key usable
  output logic            output_off_en,           // output-off key usable
  output logic            query_accept,            // query accepted pulse
  output logic            dev_clear,               // flush buffers pulse
  output logic            trig_event,              // trigger model advance pulse
  output logic            spoll_active,            // serial poll in progress
  output logic [7:0]      spoll_byte               // byte to return in poll
);
  logic [1:0]  sync_lv;                            // synchronised ren, ifc
  logic        ren_s;                              // remote enable level
  logic        ifc_raw;                            // interface clear level
  logic [16:0] ifc_cnt_r;                          // interface clear hold count
  logic        ifc_hit;                            // interface clear accepted
  logic        ifc_seen_r;                         // already acted on this assertion
  logic        m_mla, m_mta, m_ota, m_unl, m_unt;  // message decodes
  logic        m_llo, m_gtl, m_dcl, m_sdc, m_get;
  logic        m_spe, m_spd;

  ibis_sync #(.W(2)) u_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .clk_en   (clk_en),
    .async_in ({ren_pin, ifc_pin}),
    .sync_out (sync_lv)
  );
  assign ren_s   = sync_lv[1];
  assign ifc_raw = sync_lv[0];

  // compare a valid message with a code
  function automatic logic is_msg(input logic v, input logic [3:0] c, input ibis_pkg::ibis_msg_e m);
    return v && (c == 4'(m));
  endfunction

  assign m_mla = is_msg(msg_valid, msg_code, ibis_pkg::IBIS_MSG_MLA) && bus_enabled;
  assign m_mta = is_msg(msg_valid, msg_code, ibis_pkg::IBIS_MSG_MTA) && bus_enabled;
  assign m_ota = is_msg(msg_valid, msg_code, ibis_pkg::IBIS_MSG_OTA) && bus_enabled;
  assign m_unl = is_msg(msg_valid, msg_code, ibis_pkg::IBIS_MSG_UNL) && bus_enabled;
  assign m_unt = is_msg(msg_valid, msg_code, ibis_pkg::IBIS_MSG_UNT) && bus_enabled;
  assign m_llo = is_msg(msg_valid, msg_code, ibis_pkg::IBIS_MSG_LLO) && bus_enabled;
  assign m_gtl = is_msg(msg_valid, msg_code, ibis_pkg::IBIS_MSG_GTL) && bus_enabled;
  assign m_dcl = is_msg(msg_valid, msg_code, ibis_pkg::IBIS_MSG_DCL) && bus_enabled;
  assign m_sdc = is_msg(msg_valid, msg_code, ibis_pkg::IBIS_MSG_SDC) && bus_enabled;
  assign m_get = is_msg(msg_valid, msg_code, ibis_pkg::IBIS_MSG_GET) && bus_enabled;
  assign m_spe = is_msg(msg_valid, msg_code, ibis_pkg::IBIS_MSG_SPE) && bus_enabled;
  assign m_spd = is_msg(msg_valid, msg_code, ibis_pkg::IBIS_MSG_SPD) && bus_enabled;

  // interface clear must be held IFC_CYC - 1 cycles before it counts; acted on once
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ifc_cnt_r  <= '0;
      ifc_seen_r <= 1'b0;
    end else if (clk_en) begin
      if (!ifc_raw) begin
        ifc_cnt_r  <= '0;
        ifc_seen_r <= 1'b0;
      end else if (ifc_hit) begin
        ifc_seen_r <= 1'b1;
      end else if (!ifc_seen_r) begin
        ifc_cnt_r <= ifc_cnt_r + 17'h00001;
      end
    end
  end
  // hold length is the other party's duty; counted so glitches do not clear
  assign ifc_hit = ifc_raw && !ifc_seen_r && (ifc_cnt_r >= 17'(IFC_CYC - 2)); // R8

  // address and bus selection, only settings store; clears never touch them
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prim_addr   <= ibis_pkg::ADDR_RESET;                          // R1
      bus_enabled <= ibis_pkg::BUS_SEL_RESET;                       // R1
    end else if (clk_en && cfg_we) begin                            // R7 R14
      if (cfg_addr <= ibis_pkg::ADDR_MAX)
        prim_addr <= cfg_addr;                                      // R1
      bus_enabled <= cfg_bus_on;
    end
  end
  assign serial_enabled = !bus_enabled;                             // R3

  // remote / local state
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      remote_state <= 1'b0;
    end else if (clk_en) begin
      if (!ren_s || ifc_hit || !bus_enabled)
        remote_state <= 1'b0;                                       // R6
      else if (m_gtl && listener_active_indicator)
        remote_state <= 1'b0;                                       // R11
      else if (local_key && !lockout_state)
        remote_state <= 1'b0;                                       // R9
      else if (m_mla)
        remote_state <= 1'b1;                                       // R4
    end
  end

  // local lockout, dropped by go-to-local, remote enable low or power-on reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lockout_state <= 1'b0;                                        // R10
    end else if (clk_en) begin
      if ((m_gtl && listener_active_indicator) || !ren_s)
        lockout_state <= 1'b0;                                      // R10
      else if (m_llo)
        lockout_state <= 1'b1;                                      // R9
    end
  end

  // talker state
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      talker_active <= 1'b0;
    end else if (clk_en) begin
      if (ifc_hit || m_unt || m_mla || m_ota || !bus_enabled)
        talker_active <= 1'b0;                                      // R19
      else if (m_mta)
        talker_active <= 1'b1;                                      // R21
    end
  end

  // listener state
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      listener_active_indicator <= 1'b0;
    end else if (clk_en) begin
      if (ifc_hit || m_unl || m_mta || !bus_enabled)
        listener_active_indicator <= 1'b0;                          // R19
      else if (m_mla)
        listener_active_indicator <= 1'b1;                          // R21
    end
  end

  // panel key gating from the registered states
  assign panel_keys_en = !remote_state && !lockout_state;          // R18
  assign local_key_en  = remote_state && !lockout_state;           // R9
  assign output_off_en = 1'b1;                                     // R9

  // one-cycle action pulses
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      query_accept <= 1'b0;
      dev_clear    <= 1'b0;
      trig_event   <= 1'b0;
    end else if (clk_en) begin
      query_accept <= query_req && remote_state;                   // R5
      dev_clear    <= m_dcl || (m_sdc && listener_active_indicator); // R12 R13 R15
      trig_event   <= m_get && listener_active_indicator && trig_src_bus; // R16 R17
    end else begin
      query_accept <= 1'b0;
      dev_clear    <= 1'b0;
      trig_event   <= 1'b0;
    end
  end

  // serial poll mode and byte capture
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      spoll_active <= 1'b0;
      spoll_byte   <= 8'h00;
    end else if (clk_en) begin
      if (ifc_hit || m_spd)
        spoll_active <= 1'b0;
      else if (m_spe)
        spoll_active <= 1'b1;                                       // R20
      spoll_byte <= status_byte;                                    // R20
    end
  end

  chk_mla_needs_ren: assert property (@(posedge sys_clk) disable iff (srst) // R4
    $rose(remote_state) |-> $past(m_mla) && $past(ren_s)) else $error("remote entered without listen address");
  chk_ifc_idles: assert property (@(posedge sys_clk) disable iff (srst) // R6
    (clk_en && ifc_hit) |=> !talker_active && !listener_active_indicator && !remote_state)
    else $error("interface clear left a state active");
  chk_ifc_keeps_addr: assert property (@(posedge sys_clk) disable iff (srst) // R7
    (ifc_hit && !cfg_we) |=> $stable(prim_addr) && $stable(bus_enabled)) else $error("interface clear changed settings");
  chk_bus_serial_excl: assert property (@(posedge sys_clk) disable iff (srst) // R3
    bus_enabled != serial_enabled) else $error("bus and serial both on or off");
  chk_addr_range: assert property (@(posedge sys_clk) disable iff (srst) // R1
    prim_addr <= ibis_pkg::ADDR_MAX) else $error("address out of range");
  chk_query_remote: assert property (@(posedge sys_clk) disable iff (srst) // R5
    query_accept |-> $past(remote_state)) else $error("query accepted in local");
  chk_lockout_local: assert property (@(posedge sys_clk) disable iff (srst) // R9
    (lockout_state && remote_state && clk_en && local_key && ren_s && !ifc_hit && !m_gtl && bus_enabled)
    |=> remote_state) else $error("local key escaped lockout");
  chk_trig_source: assert property (@(posedge sys_clk) disable iff (srst) // R16
    trig_event |-> $past(trig_src_bus) && $past(m_get)) else $error("trigger without bus source");
  chk_dcl_unaddressed: assert property (@(posedge sys_clk) disable iff (srst) // R12
    (clk_en && m_dcl) |=> dev_clear) else $error("device clear ignored");
  chk_talk_exit: assert property (@(posedge sys_clk) disable iff (srst) // R19
    (clk_en && (m_unt || m_mla)) |=> !talker_active) else $error("talker stayed active");
  chk_remote_keys: assert property (@(posedge sys_clk) disable iff (srst) // R18
    remote_state |-> !panel_keys_en && output_off_en) else $error("panel keys usable in remote");
endmodule // ibis_core

// ==== logic/ibis_pkg.sv ====
/*
  package for the instrument bus interface state block: address range,
  factory defaults and the decoded bus message codes.
  assumes a message decoder upstream delivers one message code per cycle.
*/
package ibis_pkg;
  localparam int          ADDR_W         = 5;      // primary address width
  localparam logic [4:0]  ADDR_MAX       = 5'h1e;  // highest legal address (30)
  localparam logic [4:0]  ADDR_RESET     = 5'h10;  // factory address (16)
  localparam logic        BUS_SEL_RESET  = 1'b1;   // factory: parallel bus selected
  localparam int          IFC_MIN_NS     = 100000; // least interface clear hold
  localparam int          CLK_NS         = 8;      // sys_clk period
  localparam int          IFC_MIN_CYC    = (IFC_MIN_NS + CLK_NS - 1) / CLK_NS; // rounds up
  localparam int          MSG_W          = 4;      // message code width

  // decoded bus messages presented on msg_code with msg_valid
  typedef enum logic [3:0] {
    IBIS_MSG_NONE,  // nothing
    IBIS_MSG_MLA,   // my listen address
    IBIS_MSG_MTA,   // my talk address
    IBIS_MSG_OTA,   // other talk address
    IBIS_MSG_UNL,   // unlisten
    IBIS_MSG_UNT,   // untalk
    IBIS_MSG_LLO,   // local lockout
    IBIS_MSG_GTL,   // go to local (addressed)
    IBIS_MSG_DCL,   // device clear (universal)
    IBIS_MSG_SDC,   // selective device clear
    IBIS_MSG_GET,   // group execute trigger
    IBIS_MSG_SPE,   // serial poll enable
    IBIS_MSG_SPD    // serial poll disable
  } ibis_msg_e;
endpackage

// ==== logic/ibis_sync.sv ====
/*
  two flip-flop synchroniser for a group of pin levels.
  assumes sys_clk free running; inputs are asynchronous levels.
*/
`timescale 1ns/1ps
module ibis_sync #(
  parameter int W = 2                 // number of levels
) (
  input  wire logic         sys_clk,  // system clock
  input  wire logic         srst,     // synchronous reset
  input  wire logic         clk_en,   // clock enable
  input  wire logic [W-1:0] async_in, // raw pin levels
  output logic      [W-1:0] sync_out  // synchronised levels
);
  logic [W-1:0] meta_r;               // first stage, read only by the second

  // two stage capture
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // ibis_sync

// ==== tb/ibis_ctrl_model.sv ====
/*
  behavioural bus controller: drives remote enable, interface clear and
  decoded message strobes into the interface-state block.
  assumes sys_clk from the bench; drives everything at the falling edge.
*/
`timescale 1ns/1ps
module ibis_ctrl_model (
  input  wire logic       sys_clk,   // system clock
  output logic            ren_pin,   // remote enable line
  output logic            ifc_pin,   // interface clear line
  output logic            msg_valid, // message strobe
  output logic [3:0]      msg_code   // message code
);
  bit         req      = 1'b0;  // a message waits to go out
  logic [3:0] req_code = 4'h0;  // code of the waiting message

  // lines idle at time zero
  initial begin
    ren_pin   = 1'b0;
    ifc_pin   = 1'b0;
    msg_valid = 1'b0;
    msg_code  = 4'h5;
  end

  // one-cycle strobe; idle code keeps changing so a stale value never matches
  always @(negedge sys_clk) begin
    if (req) begin
      msg_valid <= 1'b1;
      msg_code  <= req_code;
      req = 1'b0;
    end else begin
      msg_valid <= 1'b0;
      msg_code  <= ~msg_code;
    end
  end

  // addresses of this device are only sent when meant for it
  task automatic send(input logic [3:0] c);
    @(posedge sys_clk);
    req_code = c;
    req = 1'b1;
    @(negedge sys_clk);
    @(negedge sys_clk);
  endtask

  // remote enable level, changed at a falling edge
  task automatic set_ren(input logic v);
    ren_pin = v;
  endtask

  // clear held for n cycles; n is not checked against the block's minimum
  task automatic hold_ifc(input int n);
    ifc_pin = 1'b1;
    repeat (n) @(negedge sys_clk);
    ifc_pin = 1'b0;
  endtask
endmodule // ibis_ctrl_model

// ==== tb/instrument_bus_interface_state_tb_top.sv ====
/*
  self-checking bench: a behavioural model of the interface states is
  compared with the block after every message, key press and pin change.
  assumes ibis_pkg and ibis_core; clear hold shortened to 4 cycles.
*/
`timescale 1ns/1ps
module instrument_bus_interface_state_tb_top;
  localparam int IFC_CYC = 4;                              // shortened clear hold
  logic       sys_clk = 1'b0, srst = 1'b1, clk_en = 1'b1;  // clock, reset, run
  logic       cfg_we = 1'b0, cfg_bus_on = 1'b0, trig_src_bus = 1'b0, query_req = 1'b0, local_key = 1'b0;
  logic [4:0] cfg_addr = 5'h00;                            // address to load
  logic [7:0] status_byte = 8'h00;                         // poll byte source
  logic       ren_pin, ifc_pin, msg_valid, bus_enabled, serial_enabled, remote_state, lockout_state;
  logic       talker_active, listener_active_indicator, panel_keys_en, local_key_en, output_off_en;
  logic       query_accept, dev_clear, trig_event, spoll_active;
  logic [3:0] msg_code;                                    // message code
  logic [4:0] prim_addr;                                   // address out
  logic [7:0] spoll_byte;                                  // poll byte out
  int         errors = 0, n_compared = 0;                  // score
  bit         m_rem, m_lock, m_talk, m_listener_active_indicator, m_spoll, m_ren, m_bus = 1'b1; // model state
  logic [4:0] m_addr = 5'h10;                              // model address

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  ibis_ctrl_model i_ctrl (.sys_clk(sys_clk), .ren_pin(ren_pin), .ifc_pin(ifc_pin), .msg_valid(msg_valid),
    .msg_code(msg_code));
  ibis_core #(.IFC_CYC(IFC_CYC)) i_dut (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .ren_pin(ren_pin),
    .ifc_pin(ifc_pin), .msg_valid(msg_valid), .msg_code(msg_code), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_bus_on(cfg_bus_on), .trig_src_bus(trig_src_bus), .query_req(query_req), .local_key(local_key),
    .status_byte(status_byte), .prim_addr(prim_addr), .bus_enabled(bus_enabled),
    .serial_enabled(serial_enabled), .remote_state(remote_state), .lockout_state(lockout_state),
    .talker_active(talker_active), .listener_active_indicator(listener_active_indicator),
    .panel_keys_en(panel_keys_en), .local_key_en(local_key_en), .output_off_en(output_off_en),
    .query_accept(query_accept), .dev_clear(dev_clear), .trig_event(trig_event),
    .spoll_active(spoll_active), .spoll_byte(spoll_byte));

  // verdict and end of run
  task automatic end_of_test();
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // single-bit result
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // byte-wide result
  task automatic cmp_vec(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // every state output against the model
  task automatic check_all();
    cmp_vec({3'h0, prim_addr}, {3'h0, m_addr});
    cmp_bit(bus_enabled, m_bus);
    cmp_bit(serial_enabled, !m_bus);
    cmp_bit(remote_state, m_rem);
    cmp_bit(lockout_state, m_lock);
    cmp_bit(talker_active, m_talk);
    cmp_bit(listener_active_indicator, m_listener_active_indicator);
    cmp_bit(panel_keys_en, !m_rem && !m_lock);
    cmp_bit(local_key_en, m_rem && !m_lock);
    cmp_bit(output_off_en, 1'b1);
    cmp_bit(spoll_active, m_spoll);
    cmp_vec(spoll_byte, status_byte);
  endtask

  // one bus message through the controller, model updated alongside
  task automatic msg(input ibis_pkg::ibis_msg_e c);
    bit clr, trg;
    clr = m_bus && (c == ibis_pkg::IBIS_MSG_DCL || (c == ibis_pkg::IBIS_MSG_SDC && m_listener_active_indicator));
    trg = m_bus && c == ibis_pkg::IBIS_MSG_GET && m_listener_active_indicator && trig_src_bus;
    if (m_bus) begin
      case (c)
        ibis_pkg::IBIS_MSG_MLA: begin
          m_rem = m_rem | m_ren;
          m_listener_active_indicator = 1'b1;
          m_talk = 1'b0;
        end
        ibis_pkg::IBIS_MSG_MTA: begin
          m_talk = 1'b1;
          m_listener_active_indicator = 1'b0;
        end
        ibis_pkg::IBIS_MSG_OTA, ibis_pkg::IBIS_MSG_UNT: m_talk = 1'b0;
        ibis_pkg::IBIS_MSG_UNL: m_listener_active_indicator = 1'b0;
        ibis_pkg::IBIS_MSG_LLO: m_lock = 1'b1;
        ibis_pkg::IBIS_MSG_GTL: if (m_listener_active_indicator) begin
          m_rem = 1'b0;
          m_lock = 1'b0;
        end
        ibis_pkg::IBIS_MSG_SPE: m_spoll = 1'b1;
        ibis_pkg::IBIS_MSG_SPD: m_spoll = 1'b0;
        default: ;
      endcase
    end
    i_ctrl.send(c);
    cmp_bit(dev_clear, clr);
    cmp_bit(trig_event, trg);
    check_all();
  endtask

  // query request (q) or local key press
  task automatic press(input bit q);
    bit acc;
    acc = q && m_rem;
    query_req = q;
    local_key = !q;
    if (!q && !m_lock)
      m_rem = 1'b0;
    @(negedge sys_clk);
    query_req = 1'b0;
    local_key = 1'b0;
    cmp_bit(query_accept, acc);
    check_all();
  endtask

  // remote enable change, settled through the synchroniser
  task automatic set_ren(input bit v);
    i_ctrl.set_ren(v);
    m_ren = v;
    repeat (4) @(negedge sys_clk);
    if (!v) begin
      m_rem = 1'b0;
      m_lock = 1'b0;
    end
    check_all();
  endtask

  // address and bus selection write
  task automatic cfg(input logic [4:0] a, input bit on);
    cfg_addr = a;
    cfg_bus_on = on;
    cfg_we = 1'b1;
    @(negedge sys_clk);
    cfg_we = 1'b0;
    if (a <= ibis_pkg::ADDR_MAX)
      m_addr = a;
    m_bus = on;
    check_all();
  endtask

  // hang guard: 40000 cycles, far beyond the fewer than a thousand cycles the run needs
  initial begin
    #(8 * 40000);
    errors++;
    end_of_test();
  end

  // main sequence
  initial begin
    void'($urandom(45379));
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    check_all();
    // frozen block: a message is lost and no pulse comes out
    clk_en = 1'b0;
    i_ctrl.send(ibis_pkg::IBIS_MSG_DCL);
    cmp_bit(dev_clear, 1'b0);
    check_all();
    clk_en = 1'b1;
    msg(ibis_pkg::IBIS_MSG_MLA);
    press(1'b1);
    set_ren(1'b1);
    msg(ibis_pkg::IBIS_MSG_MLA);
    press(1'b1);
    msg(ibis_pkg::IBIS_MSG_GET);
    trig_src_bus = 1'b1;
    msg(ibis_pkg::IBIS_MSG_GET);
    msg(ibis_pkg::IBIS_MSG_SDC);
    msg(ibis_pkg::IBIS_MSG_MTA);
    msg(ibis_pkg::IBIS_MSG_SDC);
    msg(ibis_pkg::IBIS_MSG_DCL);
    msg(ibis_pkg::IBIS_MSG_MLA);
    msg(ibis_pkg::IBIS_MSG_LLO);
    press(1'b0);
    msg(ibis_pkg::IBIS_MSG_GTL);
    msg(ibis_pkg::IBIS_MSG_MLA);
    press(1'b0);
    status_byte = 8'($urandom);
    msg(ibis_pkg::IBIS_MSG_SPE);
    // random mix of every message code from MLA to SPD, queries and key presses
    for (int i = 0; i < 400; i++) begin
      status_byte = 8'($urandom);
      trig_src_bus = 1'($urandom);
      if ($urandom % 4 == 0)
        press(1'($urandom));
      else
        msg(ibis_pkg::ibis_msg_e'(4'(1 + $urandom % 12)));
    end
    set_ren(1'b0);
    msg(ibis_pkg::IBIS_MSG_SPD);
    set_ren(1'b1);
    msg(ibis_pkg::IBIS_MSG_MLA);
    msg(ibis_pkg::IBIS_MSG_MTA);
    i_ctrl.hold_ifc(IFC_CYC + 2);
    repeat (4) @(negedge sys_clk);
    m_rem = 1'b0;
    m_talk = 1'b0;
    m_listener_active_indicator = 1'b0;
    m_spoll = 1'b0;
    check_all();
    cfg(5'h1e, 1'b1);
    cfg(5'h1f, 1'b1);
    cfg(5'h00, 1'b1);
    cfg(5'h10, 1'b0);
    msg(ibis_pkg::IBIS_MSG_MLA);
    cfg(5'h10, 1'b1);
    end_of_test();
  end
endmodule // instrument_bus_interface_state_tb_top
